/* core/fpn_pkg.sv */
// constants and carrier types for the front panel menu navigator
package fpn_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 16;
    localparam int T_SHORT_MS = 500;
    localparam int T_SUB_MS = 1000;
    localparam int T_SET_MS = 5000;
    localparam int REPEAT_MS = 250;
    localparam int DEBOUNCE_MS = 20;
    localparam int DARK_MS = 60000;
    localparam int HOLD_W = 13;
    localparam int DARK_W = 17;
    localparam logic [HOLD_W-1:0] T_SHORT_TK = HOLD_W'(T_SHORT_MS / TICK_MS);
    localparam logic [HOLD_W-1:0] T_SUB_TK = HOLD_W'(T_SUB_MS / TICK_MS);
    localparam logic [HOLD_W-1:0] T_SET_TK = HOLD_W'(T_SET_MS / TICK_MS);
    localparam logic [HOLD_W-1:0] REPEAT_TK = HOLD_W'(REPEAT_MS / TICK_MS);
    localparam logic [HOLD_W-1:0] DEBOUNCE_TK = HOLD_W'(DEBOUNCE_MS / TICK_MS);
    localparam int MENU_W = 3;
    localparam logic [MENU_W-1:0] MAIN_FIRST = 3'h0;
    localparam logic [MENU_W-1:0] MAIN_LAST = 3'h7;
    localparam logic [MENU_W-1:0] SUB_FIRST = 3'h0;
    localparam int DIGITS = 4;
    localparam int VALUE_W = 4 * DIGITS;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam int ADDR_W = 2 * MENU_W;
    localparam int RECORD_N = 6;
    localparam logic [RECORD_N-1:0] RECORD_ALL = 6'h3f;

    typedef struct packed {
        logic down;
        logic press;
        logic release_p;
        logic ticked;
        logic [HOLD_W-1:0] hold;
    } fpn_key_t;

    typedef struct packed {
        logic in_sub;
        logic [MENU_W-1:0] main_idx;
        logic [MENU_W-1:0] sub_idx;
    } fpn_pos_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [VALUE_W-1:0] data;
    } fpn_nv_t;

    typedef enum logic [3:0] {
        ST_BOOT = 4'h1,
        ST_DARK = 4'h2,
        ST_NAV = 4'h4,
        ST_EDIT = 4'h8
    } fpn_state_t;
endpackage

/* core/fpn_navigator.sv */
// front panel push-button interpreter: menu walk, setting mode, record and relay resets
// Functional notes
// RULE_01: dark display, step held 1 s: first entry
// RULE_02: dark display, short step: last entry
// RULE_03: records 1-6 cleared by three triggers
// RULE_04: records cleared at power-up unless retention set
// RULE_05: settings kept in non-volatile store
// RULE_06: step held over 0.5 s: forward
// RULE_07: step kept held: rapid forward browse; the code repeats only in the main menu, not in a submenu
// RULE_08: step under 0.5 s: backward
// RULE_09: program held 1 s, released: enter submenu
// RULE_10: program held 5 s toggles setting mode
// RULE_11: setting mode: step increments cursor digit
// RULE_12: setting mode: program 1 s moves cursor
// RULE_13: setting mode: step plus program stores value
// RULE_14: otherwise step plus program clears memory, latches
// RULE_15: dark display, program press releases latches only
// RULE_16: buttons synchronised, debounced, hold timed by tick
// RULE_17: short decided at release, long at threshold

module fpn_key
    import fpn_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic pin_i,
    output fpn_pkg::fpn_key_t key_o
);
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic press;
    logic rel;
    logic ticked;
    logic [HOLD_W-1:0] deb;
    logic [HOLD_W-1:0] hold;
    wire agree = (s2 == s3);
    wire differ = agree && (s3 != level);
    wire flip = differ && tick_i && (deb == DEBOUNCE_TK - HOLD_W'(1));
    wire hold_full = &hold;

    // three-stage sync, change accepted once stages two and three have agreed for DEBOUNCE_TK ticks [RULE_16]
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // debounce and hold timer on the millisecond tick [RULE_16]
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            level <= 1'b0;
            deb <= '0;
            hold <= '0;
            press <= 1'b0;
            rel <= 1'b0;
            ticked <= 1'b0;
        end
        else
        begin
            deb <= !differ || flip ? '0 : (tick_i ? deb + HOLD_W'(1) : deb);
            level <= flip ? s3 : level;
            press <= flip && s3;
            rel <= flip && !s3;
            ticked <= level && tick_i && !flip && !hold_full;
            if (flip && s3)
                hold <= '0;
            else if (level && tick_i && !hold_full)
                hold <= hold + HOLD_W'(1);
        end
    end

    assign key_o = '{down: level, press: press, release_p: rel, ticked: ticked, hold: hold};
endmodule

module fpn_navigator
    import fpn_pkg::*;
#(
    parameter int TICK_CYC = fpn_pkg::TICK_CYCLES,
    parameter int DARK_TK = fpn_pkg::DARK_MS / fpn_pkg::TICK_MS
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic step_btn_i,
    input wire logic prog_btn_i,
    input wire logic reset_btn_i,
    input wire logic ext_clear_i,
    input wire logic serial_clear_i,
    input wire logic record_retention_switch_i,
    input wire logic [fpn_pkg::VALUE_W-1:0] nv_rd_data_i,
    output logic display_on_o,
    output fpn_pkg::fpn_pos_t pos_o,
    output logic setting_mode_o,
    output logic [1:0] cursor_o,
    output logic [fpn_pkg::VALUE_W-1:0] edit_value_o,
    output fpn_pkg::fpn_nv_t nv_o,
    output logic [fpn_pkg::RECORD_N-1:0] records_clear_o,
    output logic records_restore_o,
    output logic memo_clear_o,
    output logic latch_release_o
);
    import fpn_pkg::*;

    fpn_key_t k_step;
    fpn_key_t k_prog;
    fpn_key_t k_rst;
    fpn_key_t k_ext;
    fpn_state_t state;
    fpn_state_t next_state;
    fpn_pos_t next_pos;
    logic [1:0] next_cursor;
    logic [VALUE_W-1:0] next_edit;
    logic next_commit;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic combo_lock;
    logic [HOLD_W-1:0] rep_cnt;
    logic [DARK_W-1:0] dark_cnt;

    // millisecond tick from the system clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_cnt == TICK_W'(TICK_CYC - 1));
            tick_cnt <= (tick_cnt == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt + TICK_W'(1);
        end
    end

    fpn_key u_step (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick), .pin_i(step_btn_i), .key_o(k_step));
    fpn_key u_prog (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick), .pin_i(prog_btn_i), .key_o(k_prog));
    fpn_key u_rst (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick), .pin_i(reset_btn_i), .key_o(k_rst));
    fpn_key u_ext (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick), .pin_i(ext_clear_i), .key_o(k_ext));

    // press classification
    wire combo_sp = k_step.down && k_prog.down;
    wire combo_sr = k_step.down && k_rst.down;
    wire any_down = k_step.down || k_prog.down || k_rst.down;
    wire solo = !combo_lock && !combo_sp && !combo_sr;
    wire combo_sp_go = combo_sp && !combo_lock;
    wire combo_sr_go = combo_sr && !combo_lock;
    wire step_long_hit = solo && k_step.ticked && (k_step.hold == T_SHORT_TK); // [RULE_17]
    wire step_repeat = solo && k_step.ticked && (k_step.hold > T_SHORT_TK)
        && (rep_cnt == REPEAT_TK - HOLD_W'(1));
    wire step_short_rel = solo && k_step.release_p && (k_step.hold < T_SHORT_TK); // [RULE_17]
    wire step_wake_hit = solo && k_step.ticked && (k_step.hold == T_SUB_TK);
    wire step_any_rel = solo && k_step.release_p;
    wire prog_set_hit = solo && k_prog.ticked && (k_prog.hold == T_SET_TK);
    wire prog_mid_rel = solo && k_prog.release_p && (k_prog.hold >= T_SUB_TK) && (k_prog.hold < T_SET_TK);
    wire prog_short_rel = solo && k_prog.release_p && (k_prog.hold < T_SUB_TK);
    wire dark_to = tick && (dark_cnt == DARK_W'(DARK_TK - 1));
    wire is_dark = (state == ST_DARK);
    wire is_edit = (state == ST_EDIT);
    wire step_fwd = step_long_hit || (step_repeat && !pos_o.in_sub); // [RULE_06] [RULE_07]
    wire memo_go = combo_sp_go && !is_edit && (state != ST_BOOT); // [RULE_14]
    wire latch_go = memo_go || (prog_short_rel && is_dark); // [RULE_15]
    wire rec_clear_go = combo_sr_go || k_ext.press || serial_clear_i; // [RULE_03]
    wire [ADDR_W-1:0] cur_addr = {next_pos.main_idx, next_pos.in_sub ? next_pos.sub_idx : SUB_FIRST};

    // increments one decimal digit of the edited value, wrapping after nine
    function automatic logic [VALUE_W-1:0] bump(input logic [VALUE_W-1:0] v, input logic [1:0] d);
        logic [VALUE_W-1:0] r;
        logic [3:0] n;
        r = v;
        n = v[4*d +: 4];
        r[4*d +: 4] = (n >= DIGIT_MAX) ? 4'h0 : n + 4'h1;
        return r;
    endfunction

    always_comb
    begin
        next_state = state;
        next_pos = pos_o;
        next_cursor = cursor_o;
        next_edit = edit_value_o;
        next_commit = 1'b0;
        unique case (state)
            ST_BOOT:
                next_state = ST_DARK;
            ST_DARK:
                if (step_wake_hit)
                begin
                    next_state = ST_NAV; // [RULE_01]
                    next_pos = '{in_sub: 1'b0, main_idx: MAIN_FIRST, sub_idx: SUB_FIRST};
                end
                else if (step_short_rel)
                begin
                    next_state = ST_NAV; // [RULE_02]
                    next_pos = '{in_sub: 1'b0, main_idx: MAIN_LAST, sub_idx: SUB_FIRST};
                end
            ST_NAV:
                if (dark_to)
                    next_state = ST_DARK;
                else if (prog_set_hit)
                begin
                    next_state = ST_EDIT; // [RULE_10]
                    next_edit = nv_rd_data_i;
                    next_cursor = 2'h0;
                end
                else if (step_fwd && pos_o.in_sub)
                    next_pos.sub_idx = pos_o.sub_idx + MENU_W'(1); // [RULE_06]
                else if (step_fwd)
                    next_pos.main_idx = pos_o.main_idx + MENU_W'(1); // [RULE_06] [RULE_07]
                else if (step_short_rel && pos_o.in_sub && pos_o.sub_idx == SUB_FIRST)
                    next_pos.in_sub = 1'b0;
                else if (step_short_rel && pos_o.in_sub)
                    next_pos.sub_idx = pos_o.sub_idx - MENU_W'(1); // [RULE_08]
                else if (step_short_rel)
                    next_pos.main_idx = pos_o.main_idx - MENU_W'(1); // [RULE_08]
                else if (prog_mid_rel && !pos_o.in_sub)
                begin
                    next_pos.in_sub = 1'b1; // [RULE_09]
                    next_pos.sub_idx = SUB_FIRST;
                end
            ST_EDIT:
                if (dark_to)
                    next_state = ST_DARK;
                else if (prog_set_hit)
                    next_state = ST_NAV; // [RULE_10]
                else if (combo_sp_go)
                    next_commit = 1'b1; // [RULE_13]
                else if (step_any_rel)
                    next_edit = bump(edit_value_o, cursor_o); // [RULE_11]
                else if (prog_mid_rel)
                    next_cursor = cursor_o + 2'h1; // [RULE_12]
        endcase
    end

    // combo lock, repeat pacing and inactivity timer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            combo_lock <= 1'b0;
            rep_cnt <= '0;
            dark_cnt <= '0;
        end
        else
        begin
            combo_lock <= any_down && (combo_lock || combo_sp || combo_sr);
            rep_cnt <= (!k_step.down || step_long_hit || step_repeat) ? '0
                : (k_step.ticked ? rep_cnt + HOLD_W'(1) : rep_cnt); // [RULE_07]
            dark_cnt <= (any_down || is_dark) ? '0 : (tick ? dark_cnt + DARK_W'(1) : dark_cnt);
        end
    end

    // navigation state and registered outputs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_BOOT;
            pos_o <= '0;
            cursor_o <= 2'h0;
            edit_value_o <= '0;
            display_on_o <= 1'b0;
            setting_mode_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            pos_o <= next_pos;
            cursor_o <= next_cursor;
            edit_value_o <= next_edit;
            display_on_o <= (next_state == ST_NAV) || (next_state == ST_EDIT);
            setting_mode_o <= (next_state == ST_EDIT);
        end
    end

    // pulses toward record store, relays and non-volatile setting store
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nv_o <= '0;
            records_clear_o <= '0;
            records_restore_o <= 1'b0;
            memo_clear_o <= 1'b0;
            latch_release_o <= 1'b0;
        end
        else
        begin
            nv_o.wr <= next_commit; // [RULE_05]
            nv_o.addr <= cur_addr;
            nv_o.data <= next_commit ? edit_value_o : nv_o.data;
            records_clear_o <= (rec_clear_go || (state == ST_BOOT && !record_retention_switch_i))
                ? RECORD_ALL : '0; // [RULE_03] [RULE_04]
            records_restore_o <= (state == ST_BOOT) && record_retention_switch_i; // [RULE_04]
            memo_clear_o <= memo_go; // [RULE_14]
            latch_release_o <= latch_go; // [RULE_14] [RULE_15]
        end
    end
endmodule

/* tb/fpn_navigator_sva.sv */
// port assertions for the front panel menu navigator
module fpn_navigator_sva
    import fpn_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic serial_clear_i,
    input wire logic record_retention_switch_i,
    input wire logic [fpn_pkg::VALUE_W-1:0] nv_rd_data_i,
    input wire logic display_on_o,
    input wire logic setting_mode_o,
    input wire logic [1:0] cursor_o,
    input wire logic [fpn_pkg::VALUE_W-1:0] edit_value_o,
    input fpn_pkg::fpn_nv_t nv_o,
    input wire logic [fpn_pkg::RECORD_N-1:0] records_clear_o,
    input wire logic records_restore_o,
    input wire logic memo_clear_o,
    input wire logic latch_release_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_clear_all: assert property (records_clear_o != '0 |-> records_clear_o == RECORD_ALL)
        else $error("partial record clear");
    chk_serial_clear: assert property (serial_clear_i |-> ##[1:3] records_clear_o == RECORD_ALL)
        else $error("serial clear lost");
    chk_restore_kept: assert property (records_restore_o |-> record_retention_switch_i && records_clear_o == '0)
        else $error("restore without retention");
    chk_edit_load: assert property ($rose(setting_mode_o) |-> edit_value_o == nv_rd_data_i && cursor_o == 2'h0)
        else $error("edit buffer not loaded");
    chk_edit_shown: assert property (setting_mode_o |-> display_on_o)
        else $error("setting mode while dark");
    chk_cursor_step: assert property (setting_mode_o && $past(setting_mode_o) && cursor_o != $past(cursor_o)
        |-> cursor_o == 2'($past(cursor_o) + 2'h1))
        else $error("cursor jump");
    chk_commit_data: assert property (nv_o.wr |-> setting_mode_o && nv_o.data == edit_value_o)
        else $error("bad store");
    chk_memo_pair: assert property (memo_clear_o |-> latch_release_o && !setting_mode_o ##1 !memo_clear_o)
        else $error("memo clear pulse wrong");
    chk_latch_dark: assert property (latch_release_o && !memo_clear_o |-> !display_on_o)
        else $error("latch release while lit");

    cover property ($rose(setting_mode_o));
    cover property (nv_o.wr);
    cover property (memo_clear_o);
    cover property (records_restore_o);
endmodule

bind fpn_navigator fpn_navigator_sva i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clear_i(serial_clear_i),
    .record_retention_switch_i(record_retention_switch_i), .nv_rd_data_i(nv_rd_data_i),
    .display_on_o(display_on_o), .setting_mode_o(setting_mode_o), .cursor_o(cursor_o),
    .edit_value_o(edit_value_o), .nv_o(nv_o), .records_clear_o(records_clear_o),
    .records_restore_o(records_restore_o), .memo_clear_o(memo_clear_o), .latch_release_o(latch_release_o));

/* tb/fpn_operator.sv */
// operator model pressing the front panel buttons
module fpn_operator
#(
    parameter int TICK_CYC = 4
)
(
    input wire logic clk_i,
    output logic step_o,
    output logic prog_o,
    output logic reset_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {step_o, prog_o, reset_o} = 3'h0;
    end

    // contacts bounce before they settle
    task automatic press(input logic [2:0] mask);
        for (int i = 0; i < 7; i++)
        begin
            @(negedge clk_i);
            {step_o, prog_o, reset_o} = i[0] ? 3'h0 : mask;
        end
    endtask

    task automatic hold_ms(input int ms);
        repeat (ms * TICK_CYC) @(negedge clk_i);
    endtask

    task automatic release_all();
        @(negedge clk_i);
        {step_o, prog_o, reset_o} = 3'h0;
        hold_ms(40);
    endtask
endmodule

/* tb/fpn_navigator_tb.sv */
// self-checking testbench for the front panel menu navigator
module fpn_navigator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpn_pkg::*;

    localparam int TK = 4;
    logic clk;
    logic rst_n;
    logic ext_clr;
    logic ser_clr;
    logic keep;
    logic [15:0] nv_rd;
    logic step, prog, rbtn, disp, smode, rest, memo, latch;
    logic [1:0] cur;
    logic [15:0] edit, wr_data;
    logic [5:0] rclr, wr_addr;
    fpn_pos_t pos;
    fpn_nv_t nv;
    int mismatches = 0;
    int n_tests = 0;
    int n_clr = 0, n_rest = 0, n_memo = 0, n_latch = 0, n_wr = 0;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    fpn_navigator #(.TICK_CYC(TK), .DARK_TK(200)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .step_btn_i(step),
        .prog_btn_i(prog), .reset_btn_i(rbtn), .ext_clear_i(ext_clr), .serial_clear_i(ser_clr),
        .record_retention_switch_i(keep), .nv_rd_data_i(nv_rd), .display_on_o(disp), .pos_o(pos),
        .setting_mode_o(smode), .cursor_o(cur), .edit_value_o(edit), .nv_o(nv), .records_clear_o(rclr),
        .records_restore_o(rest), .memo_clear_o(memo), .latch_release_o(latch));
    fpn_operator #(.TICK_CYC(TK)) i_op (.clk_i(clk), .step_o(step), .prog_o(prog), .reset_o(rbtn));

    // pulses are counted at the falling edge, where they have settled
    always @(negedge clk)
    begin
        if (rclr === RECORD_ALL) n_clr++;
        if (rest === 1'b1) n_rest++;
        if (memo === 1'b1) n_memo++;
        if (latch === 1'b1) n_latch++;
        if (nv.wr === 1'b1)
        begin
            n_wr++;
            wr_data = nv.data;
            wr_addr = nv.addr;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // step = 4, prog = 2, reset = 1
    task automatic push(input logic [2:0] m, input int ms);
        i_op.press(m);
        i_op.hold_ms(ms);
        i_op.release_all();
    endtask

    task automatic t_power();
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        check("clear", 16'(n_clr), 16'h1);
        keep = 1'b1;
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        check("restore", 16'(n_rest), 16'h1);
        check("clear", 16'(n_clr), 16'h1);
        $display("power done");
    endtask

    task automatic t_browse();
        push(3'h4, 200);
        check("display", 16'(disp), 16'h1);
        check("main", 16'(pos.main_idx), 16'h7);
        push(3'h4, 200);
        check("main", 16'(pos.main_idx), 16'h6);
        i_op.press(3'h4);
        i_op.hold_ms(560);
        check("main", 16'(pos.main_idx), 16'h7);
        i_op.release_all();
        push(3'h4, 1100);
        check("main", 16'(pos.main_idx), 16'h2);
        push(3'h2, 1200);
        check("in_sub", 16'(pos.in_sub), 16'h1);
        push(3'h4, 600);
        check("sub", 16'(pos.sub_idx), 16'h1);
        $display("browse done");
    endtask

    task automatic t_edit();
        push(3'h2, 5500);
        check("mode", 16'(smode), 16'h1);
        check("edit", edit, 16'h0123);
        push(3'h4, 200);
        check("edit", edit, 16'h0124);
        push(3'h2, 1200);
        check("cursor", 16'(cur), 16'h1);
        push(3'h4, 200);
        check("edit", edit, 16'h0134);
        push(3'h6, 200);
        check("stores", 16'(n_wr), 16'h1);
        check("stored", wr_data, 16'h0134);
        check("memo", 16'(n_memo), 16'h0);
        check("addr", 16'(wr_addr), 16'h11);
        push(3'h2, 5100);
        check("mode", 16'(smode), 16'h0);
        check("display", 16'(disp), 16'h1);
        i_op.hold_ms(250);
        check("display", 16'(disp), 16'h0);
        $display("edit done");
    endtask

    task automatic t_dark_keys();
        push(3'h2, 200);
        check("latch", 16'(n_latch), 16'h1);
        check("memo", 16'(n_memo), 16'h0);
        push(3'h6, 200);
        check("memo", 16'(n_memo), 16'h1);
        check("latch", 16'(n_latch), 16'h2);
        push(3'h5, 200);
        check("clear", 16'(n_clr), 16'h2);
        ext_clr = 1'b1;
        i_op.hold_ms(40);
        ext_clr = 1'b0;
        i_op.hold_ms(40);
        check("clear", 16'(n_clr), 16'h3);
        ser_clr = 1'b1;
        @(negedge clk);
        ser_clr = 1'b0;
        repeat (5) @(negedge clk);
        check("clear", 16'(n_clr), 16'h4);
        i_op.hold_ms(250);
        push(3'h4, 1200);
        check("display", 16'(disp), 16'h1);
        check("main", 16'(pos.main_idx), 16'h0);
        $display("dark keys done");
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial
    begin
        rst_n = 1'b0;
        ext_clr = 1'b0;
        ser_clr = 1'b0;
        keep = 1'b0;
        nv_rd = 16'h0123;
        t_power();
        t_browse();
        t_edit();
        t_dark_keys();
        end_sim();
    end
endmodule
